// *** pm_regs_defs.vh ***
// Command codes, reset values and fixed settings of the power manager register bank.
`ifndef PM_REGS_DEFS_VH
`define PM_REGS_DEFS_VH

`define CMD_IOUT_FLAGS   8'h7b
`define CMD_INPUT_FLAGS  8'h7c
`define CMD_TEMP_FLAGS   8'h7d
`define CMD_COMM_FLAGS   8'h7e
`define CMD_VEND_FLAGS   8'h80
`define CMD_VIN          8'h88
`define CMD_VOUT         8'h8b
`define CMD_IOUT         8'h8c
`define CMD_EXT_TEMP     8'h8d
`define CMD_DIE_TEMP     8'h8e
`define CMD_POUT         8'h96
`define CMD_PROTO_REV    8'h98
`define CMD_TOOL_A       8'hb0
`define CMD_TOOL_B       8'hb1
`define CMD_OEM          8'hb2
`define CMD_SCR_PAGED    8'hb3
`define CMD_SCR_SHARED   8'hb4
`define CMD_VRES_A       8'hb5
`define CMD_SELF_HEAT    8'hb8
`define CMD_TAU_INV      8'hb9
`define CMD_THETA        8'hba
`define CMD_IOUT_FIXED   8'hbb
`define CMD_VRES_B       8'hbc
`define CMD_NVM_UNLOCK   8'hbd
`define CMD_NVM_ERASE    8'hbe
`define CMD_NVM_DATA     8'hbf
`define CMD_CH_CFG       8'hd0
`define CMD_GL_CFG       8'hd1
`define CMD_PROP_A       8'hd2
`define CMD_PROP_B       8'hd3
`define CMD_PG_MAP       8'hd4
`define CMD_RESP_A       8'hd5
`define CMD_RESP_B       8'hd6
`define CMD_IOUT_MAX     8'hd7
`define CMD_IOUT_MIN     8'hd8
`define CMD_CH_CFG2      8'hd9

`define RST_WORD0        16'h0000
`define RST_BYTE0        8'h00
`define RST_L11_ZERO     16'h8000
`define RST_CH_CFG       16'h0080
`define RST_GL_CFG       16'h0f7b
`define PROTO_REV_VALUE  8'h11
`define NVM_UNLOCK_KEY   8'h5a
`define NVM_ERASED       16'hffff
`define NVM_PTR_LAST     6'h3f
`define SH_CONV_LAST     2'h3
`define SH_SHIFT         11
`define MANT_MSB         10
`define PROP_EN_BIT      0
`define PG_CH_MSB        3
`define PG_WDT_BIT       8
`define ALL_CH_GOOD      4'hf

`endif

// *** current_extreme_tracker.v ***
// Per-channel largest and smallest output current tracker.
`include "pm_regs_defs.vh"

module current_extreme_tracker (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        sampleValid,
  input  wire [1:0]  sampleChan,
  input  wire [15:0] sampleKey,
  input  wire [15:0] sampleWord,
  input  wire [1:0]  readChan,
  output wire [15:0] maxWord,
  output wire [15:0] minWord
);

  reg [3:0]  seen;
  reg [15:0] maxKey  [0:3];
  reg [15:0] minKey  [0:3];
  reg [15:0] maxWd   [0:3];
  reg [15:0] minWd   [0:3];
  integer    i;

  // The fixed-point reading orders samples; the float word is what gets reported.
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      seen <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        {maxKey[i], minKey[i]} <= {2{`RST_WORD0}};
        {maxWd[i], minWd[i]}   <= {2{`RST_L11_ZERO}};
      end
    end else if (sampleValid) begin
      seen[sampleChan] <= 1'b1;
      if (!seen[sampleChan] || sampleKey > maxKey[sampleChan]) begin
        maxKey[sampleChan] <= sampleKey;
        maxWd[sampleChan]  <= sampleWord;
      end
      if (!seen[sampleChan] || sampleKey < minKey[sampleChan]) begin
        minKey[sampleChan] <= sampleKey;
        minWd[sampleChan]  <= sampleWord;
      end
    end
  end

  // Readout follows the selected page.
  assign maxWord = maxWd[readChan];
  assign minWord = minWd[readChan];

endmodule // current_extreme_tracker

// *** power_manager_status_telemetry_regs.v ***
// Command-addressed status, telemetry and configuration register bank.
// How it works
// - Paged output current status byte.
// - Unpaged input supply status byte.
// - Paged external temperature status byte.
// - Unpaged comms and memory status byte.
// - Paged vendor fault and state byte.
// - Unpaged input voltage word.
// - Paged voltage, current and power.
// - Paged external diode temperature word, read back as captured.
// - Unpaged die temperature word.
// - Protocol revision reads 1.1.
// - Paged and shared scratchpads, zero default.
// - Per-channel self-heating rise.
// - Self-heat from tau and theta.
// - Fixed-point current, 2.5 mA per bit.
// - Memory access refused until unlocked.
// - Erase initialises user memory.
// - Data port advances per access.
// - Channel and global configuration defaults.
// - Per-channel fault propagation to pins.
// - Response to externally pulled fault pins.
// - Power-good pin from mapping word.
// - Per-channel peak and minimum current.
`include "pm_regs_defs.vh"

module power_manager_status_telemetry_regs (
  input  wire        clk_sys,
  input  wire        sys_rst,
  input  wire        cmdValid,
  input  wire        cmdWrite,
  input  wire [7:0]  cmdCode,
  input  wire [15:0] wrData,
  input  wire [1:0]  pageSel,
  input  wire [31:0] chanIoutStatus,
  input  wire [7:0]  inputStatus,
  input  wire [31:0] chanTempStatus,
  input  wire [7:0]  commStatus,
  input  wire [31:0] chanVendorStatus,
  input  wire [15:0] vinWord,
  input  wire [15:0] dieTempWord,
  input  wire        telemValid,
  input  wire [1:0]  telemChan,
  input  wire [15:0] telemVout,
  input  wire [15:0] telemIout,
  input  wire [15:0] telemIoutFixed,
  input  wire [15:0] telemPout,
  input  wire [15:0] telemTemp,
  input  wire [3:0]  chanFaultedOff,
  input  wire [3:0]  chanPowerGood,
  input  wire        watchdogOkPin,
  input  wire        faultPinAIn,
  input  wire        faultPinBIn,
  output reg         faultPinAOut,
  output reg         faultPinAOe,
  output reg         faultPinBOut,
  output reg         faultPinBOe,
  output reg  [7:0]  faultActionA,
  output reg  [7:0]  faultActionB,
  output reg         pwrGoodOut,
  output reg  [15:0] rdData,
  output reg         cmdAck,
  output reg         cmdRefused
);

  // Per-channel writable state.
  reg [15:0] toolB [0:3], scrPaged [0:3], vresA [0:3], vresB [0:3];
  reg [15:0] tauInv [0:3], theta [0:3], chCfg [0:3];
  reg [7:0]  propA [0:3], propB [0:3];
  // Per-channel telemetry captures.
  reg [15:0] voutRd [0:3], ioutRd [0:3], ioutFx [0:3], poutRd [0:3], extTemp [0:3];
  reg [10:0] selfRise [0:3];
  reg [1:0]  convCnt [0:3];
  // Shared writable state.
  reg [15:0] toolA, oemWord, scrShared, glCfg, pgMap;
  reg [7:0]  respA, respB, chCfg2;
  // User memory behind the unlock gate.
  reg [15:0] nvmMem [0:63];
  reg [5:0]  nvmPtr;
  reg        nvmUnlocked, nvmSweeping;
  // Pin synchronisers.
  reg        pinASync1, pinASync2, pinBSync1, pinBSync2, wdtSync1, wdtSync2;
  reg [15:0] readMux;
  reg        readHit, writeHit;
  reg [10:0] heatTarget, next_rise;
  reg [21:0] heatProd;
  reg signed [23:0] riseDiff, riseStep;
  reg [3:0]  propEnA, propEnB;
  integer    i, j;

  wire [1:0]  page = pageSel;
  wire        nvmOpen = nvmUnlocked && !nvmSweeping;
  wire        isRead = cmdValid && !cmdWrite;
  wire        isWrite = cmdValid && cmdWrite;
  wire [15:0] ioutMax, ioutMin;

  // Picks one channel's byte out of a packed four-channel status bus.
  function [15:0] chanByte;
    input [31:0] bus;
    input [1:0]  idx;
    begin
      chanByte = {8'h00, bus[idx * 8 +: 8]};
    end
  endfunction

  // Peak and minimum tracking keyed on the fixed-point current.
  current_extreme_tracker extremes (
    .clk_sys    (clk_sys),
    .sys_rst    (sys_rst),
    .sampleValid(telemValid),
    .sampleChan (telemChan),
    .sampleKey  (telemIoutFixed),
    .sampleWord (telemIout),
    .readChan   (page),
    .maxWord    (ioutMax),
    .minWord    (ioutMin)
  );

  // Read decode; unpaged commands never index by page.
  always @* begin
    readMux = `RST_WORD0;
    readHit = 1'b1;
    if (cmdCode == `CMD_IOUT_FLAGS) begin
      readMux = chanByte(chanIoutStatus, page);
    end else if (cmdCode == `CMD_INPUT_FLAGS) begin
      readMux = {8'h00, inputStatus};
    end else if (cmdCode == `CMD_TEMP_FLAGS) begin
      readMux = chanByte(chanTempStatus, page);
    end else if (cmdCode == `CMD_COMM_FLAGS) begin
      readMux = {8'h00, commStatus};
    end else if (cmdCode == `CMD_VEND_FLAGS) begin
      readMux = chanByte(chanVendorStatus, page);
    end else if (cmdCode == `CMD_VIN) begin
      readMux = vinWord;
    end else if (cmdCode == `CMD_VOUT) begin
      readMux = voutRd[page];
    end else if (cmdCode == `CMD_IOUT) begin
      readMux = ioutRd[page];
    end else if (cmdCode == `CMD_POUT) begin
      readMux = poutRd[page];
    end else if (cmdCode == `CMD_EXT_TEMP) begin
      readMux = extTemp[page];
    end else if (cmdCode == `CMD_DIE_TEMP) begin
      readMux = dieTempWord;
    end else if (cmdCode == `CMD_PROTO_REV) begin
      readMux = {8'h00, `PROTO_REV_VALUE};
    end else if (cmdCode == `CMD_TOOL_A) begin
      readMux = toolA;
    end else if (cmdCode == `CMD_TOOL_B) begin
      readMux = toolB[page];
    end else if (cmdCode == `CMD_OEM) begin
      readMux = oemWord;
    end else if (cmdCode == `CMD_SCR_PAGED) begin
      readMux = scrPaged[page];
    end else if (cmdCode == `CMD_SCR_SHARED) begin
      readMux = scrShared;
    end else if (cmdCode == `CMD_VRES_A) begin
      readMux = vresA[page];
    end else if (cmdCode == `CMD_SELF_HEAT) begin
      readMux = {5'h00, selfRise[page]};
    end else if (cmdCode == `CMD_TAU_INV) begin
      readMux = tauInv[page];
    end else if (cmdCode == `CMD_THETA) begin
      readMux = theta[page];
    end else if (cmdCode == `CMD_IOUT_FIXED) begin
      readMux = ioutFx[page];
    end else if (cmdCode == `CMD_VRES_B) begin
      readMux = vresB[page];
    end else if (cmdCode == `CMD_NVM_UNLOCK) begin
      readMux = {15'h0000, nvmUnlocked};
    end else if (cmdCode == `CMD_NVM_ERASE) begin
      readMux = {15'h0000, nvmSweeping};
    end else if (cmdCode == `CMD_NVM_DATA) begin
      readMux = nvmMem[nvmPtr];
      readHit = nvmOpen;
    end else if (cmdCode == `CMD_CH_CFG) begin
      readMux = chCfg[page];
    end else if (cmdCode == `CMD_GL_CFG) begin
      readMux = glCfg;
    end else if (cmdCode == `CMD_PROP_A) begin
      readMux = {8'h00, propA[page]};
    end else if (cmdCode == `CMD_PROP_B) begin
      readMux = {8'h00, propB[page]};
    end else if (cmdCode == `CMD_PG_MAP) begin
      readMux = pgMap;
    end else if (cmdCode == `CMD_RESP_A) begin
      readMux = {8'h00, respA};
    end else if (cmdCode == `CMD_RESP_B) begin
      readMux = {8'h00, respB};
    end else if (cmdCode == `CMD_IOUT_MAX) begin
      readMux = ioutMax;
    end else if (cmdCode == `CMD_IOUT_MIN) begin
      readMux = ioutMin;
    end else if (cmdCode == `CMD_CH_CFG2) begin
      readMux = {8'h00, chCfg2};
    end else begin
      readHit = 1'b0;
    end
  end

  // Write acceptance; erase and data commands wait for the unlock and for a finished erase.
  always @* begin
    writeHit = 1'b1;
    if ((cmdCode == `CMD_NVM_ERASE) || (cmdCode == `CMD_NVM_DATA)) begin
      writeHit = nvmOpen;
    end else if (((cmdCode >= `CMD_TOOL_A) && (cmdCode <= `CMD_VRES_A)) ||
                 ((cmdCode >= `CMD_CH_CFG) && (cmdCode <= `CMD_RESP_B)) ||
                 (cmdCode == `CMD_TAU_INV) || (cmdCode == `CMD_THETA) ||
                 (cmdCode == `CMD_VRES_B) || (cmdCode == `CMD_NVM_UNLOCK) ||
                 (cmdCode == `CMD_CH_CFG2)) begin
      writeHit = 1'b1;
    end else begin
      writeHit = 1'b0;
    end
  end

  // Self-heating: the rise chases theta times current, weighted by tau.
  // Mantissas are used as plain fixed-point, which keeps the filter cheap.
  always @* begin
    heatProd   = theta[telemChan][`MANT_MSB:0] * telemIoutFixed[`MANT_MSB:0];
    heatTarget = heatProd[21:`SH_SHIFT];
    riseDiff   = $signed({13'h0000, heatTarget}) -
                 $signed({13'h0000, selfRise[telemChan]});
    riseStep   = (riseDiff * $signed({13'h0000, tauInv[telemChan][`MANT_MSB:0]}))
                 >>> `SH_SHIFT;
    next_rise  = selfRise[telemChan] + riseStep[10:0];
  end

  // Register writes, telemetry captures and the memory pointer.
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      for (i = 0; i < 4; i = i + 1) begin
        {toolB[i], scrPaged[i], vresA[i], vresB[i]} <= {4{`RST_WORD0}};
        {tauInv[i], theta[i]} <= {2{`RST_L11_ZERO}};
        chCfg[i] <= `RST_CH_CFG;
        {propA[i], propB[i]} <= {2{`RST_BYTE0}};
        {voutRd[i], ioutFx[i]} <= {2{`RST_WORD0}};
        {ioutRd[i], poutRd[i], extTemp[i]} <= {3{`RST_L11_ZERO}};
        {selfRise[i], convCnt[i]} <= 13'h0000;
      end
      {toolA, oemWord, scrShared, pgMap} <= {4{`RST_WORD0}};
      glCfg  <= `RST_GL_CFG;
      {respA, respB, chCfg2} <= {3{`RST_BYTE0}};
      nvmPtr <= 6'h00;
      {nvmUnlocked, nvmSweeping} <= 2'b00;
    end else begin
      if (telemValid) begin
        voutRd[telemChan]  <= telemVout;
        {ioutRd[telemChan], poutRd[telemChan]} <= {telemIout, telemPout};
        ioutFx[telemChan]  <= telemIoutFixed;
        extTemp[telemChan] <= telemTemp;
        convCnt[telemChan] <= convCnt[telemChan] + 2'h1;
        if (convCnt[telemChan] == `SH_CONV_LAST) begin
          selfRise[telemChan] <= next_rise;
        end
      end
      if (nvmSweeping) begin
        nvmPtr <= nvmPtr + 6'h01;
        if (nvmPtr == `NVM_PTR_LAST) begin
          nvmSweeping <= 1'b0;
        end
      end else if (isRead && readHit && cmdCode == `CMD_NVM_DATA) begin
        nvmPtr <= nvmPtr + 6'h01;
      end
      if (isWrite && writeHit) begin
        if (cmdCode == `CMD_NVM_UNLOCK) begin
          nvmUnlocked <= (wrData[7:0] == `NVM_UNLOCK_KEY);
        end else if (cmdCode == `CMD_NVM_ERASE) begin
          nvmSweeping <= 1'b1;
          nvmPtr      <= 6'h00;
        end else if (cmdCode == `CMD_NVM_DATA) begin
          nvmPtr <= nvmPtr + 6'h01;
        end else if (cmdCode == `CMD_TOOL_A) begin
          toolA <= wrData;
        end else if (cmdCode == `CMD_TOOL_B) begin
          toolB[page] <= wrData;
        end else if (cmdCode == `CMD_OEM) begin
          oemWord <= wrData;
        end else if (cmdCode == `CMD_SCR_PAGED) begin
          scrPaged[page] <= wrData;
        end else if (cmdCode == `CMD_SCR_SHARED) begin
          scrShared <= wrData;
        end else if (cmdCode == `CMD_VRES_A) begin
          vresA[page] <= wrData;
        end else if (cmdCode == `CMD_VRES_B) begin
          vresB[page] <= wrData;
        end else if (cmdCode == `CMD_TAU_INV) begin
          tauInv[page] <= wrData;
        end else if (cmdCode == `CMD_THETA) begin
          theta[page] <= wrData;
        end else if (cmdCode == `CMD_CH_CFG) begin
          chCfg[page] <= wrData;
        end else if (cmdCode == `CMD_GL_CFG) begin
          glCfg <= wrData;
        end else if (cmdCode == `CMD_PROP_A) begin
          propA[page] <= wrData[7:0];
        end else if (cmdCode == `CMD_PROP_B) begin
          propB[page] <= wrData[7:0];
        end else if (cmdCode == `CMD_PG_MAP) begin
          pgMap <= wrData;
        end else if (cmdCode == `CMD_RESP_A) begin
          respA <= wrData[7:0];
        end else if (cmdCode == `CMD_RESP_B) begin
          respB <= wrData[7:0];
        end else begin
          chCfg2 <= wrData[7:0];
        end
      end
    end
  end

  // Memory array has no reset; erase sweeps it one word per clock.
  always @(posedge clk_sys) begin
    if (nvmSweeping) begin
      nvmMem[nvmPtr] <= `NVM_ERASED;
    end else if (isWrite && writeHit && cmdCode == `CMD_NVM_DATA) begin
      nvmMem[nvmPtr] <= wrData;
    end
  end

  // Answer one clock after the command; unknown or locked commands are refused.
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      {rdData, cmdAck, cmdRefused} <= {`RST_WORD0, 2'b00};
    end else begin
      cmdAck     <= cmdValid && (cmdWrite ? writeHit : readHit);
      cmdRefused <= cmdValid && !(cmdWrite ? writeHit : readHit);
      if (isRead && readHit) begin
        rdData <= readMux;
      end
    end
  end

  // Pin inputs pass two flops before any logic looks at them.
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      {pinASync1, pinASync2, pinBSync1, pinBSync2} <= 4'hf;
      {wdtSync1, wdtSync2} <= 2'b00;
    end else begin
      {pinASync2, pinASync1} <= {pinASync1, faultPinAIn};
      {pinBSync2, pinBSync1} <= {pinBSync1, faultPinBIn};
      {wdtSync2, wdtSync1}   <= {wdtSync1, watchdogOkPin};
    end
  end

  // Enable bit of each channel's propagation byte.
  always @* begin
    for (j = 0; j < 4; j = j + 1) begin
      propEnA[j] = propA[j][`PROP_EN_BIT];
      propEnB[j] = propB[j][`PROP_EN_BIT];
    end
  end

  // Fault pins and power good. Our own pull-down is masked only while its enable is high;
  // the synchronised pin lags it, so for two clocks after release faultActionA or faultActionB still takes the response byte.
  always @(posedge clk_sys) begin
    if (sys_rst) begin
      {faultPinAOut, faultPinAOe, faultPinBOut, faultPinBOe, pwrGoodOut} <= 5'h00;
      {faultActionA, faultActionB} <= {2{`RST_BYTE0}};
    end else begin
      {faultPinAOut, faultPinBOut} <= 2'b00;
      faultPinAOe  <= |(chanFaultedOff & propEnA);
      faultPinBOe  <= |(chanFaultedOff & propEnB);
      faultActionA <= (!pinASync2 && !faultPinAOe) ? respA : `RST_BYTE0;
      faultActionB <= (!pinBSync2 && !faultPinBOe) ? respB : `RST_BYTE0;
      pwrGoodOut   <= ((chanPowerGood | ~pgMap[`PG_CH_MSB:0]) == `ALL_CH_GOOD) &&
                      (!pgMap[`PG_WDT_BIT] || wdtSync2);
    end
  end

endmodule // power_manager_status_telemetry_regs

// *** pm_regs_checker_assertions.sv ***
// Port checks for the power manager register bank.
module pm_regs_checker (
  input wire        clk_sys,
  input wire        sys_rst,
  input wire        cmdValid,
  input wire        cmdWrite,
  input wire [7:0]  cmdCode,
  input wire [1:0]  pageSel,
  input wire [31:0] chanIoutStatus,
  input wire [7:0]  inputStatus,
  input wire [15:0] vinWord,
  input wire        faultPinAIn,
  input wire        faultPinAOut,
  input wire        faultPinBOut,
  input wire [7:0]  faultActionA,
  input wire [15:0] rdData,
  input wire        cmdAck,
  input wire        cmdRefused
);
  // One clock domain; reset silences every check.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Read strobe, and the status byte of the selected page moved to the bottom.
  wire        rdCmd = cmdValid && !cmdWrite;
  wire [31:0] shIout = chanIoutStatus >> {pageSel, 3'b000};
  a_one_answer: assert property (cmdValid |=> cmdAck != cmdRefused)
    else $error("command not answered exactly once");
  a_idle_quiet: assert property (!cmdValid |=> !cmdAck && !cmdRefused)
    else $error("answer without a command");
  a_rev_fixed: assert property (rdCmd && cmdCode == 8'h98 |=> rdData == 16'h0011)
    else $error("revision byte wrong");
  a_ro_refused: assert property (cmdValid && (cmdWrite && cmdCode == 8'h7b || cmdCode == 8'h81)
    |=> cmdRefused)
    else $error("bad access not refused");
  a_vin_live: assert property (rdCmd && cmdCode == 8'h88 |=> rdData == $past(vinWord))
    else $error("input voltage word wrong");
  a_input_flags: assert property (rdCmd && cmdCode == 8'h7c
    |=> rdData == {8'h00, $past(inputStatus)}) else $error("input status byte wrong");
  a_paged_flags: assert property (rdCmd && cmdCode == 8'h7b
    |=> rdData == {8'h00, $past(shIout[7:0])}) else $error("paged status byte wrong");
  a_pins_low: assert property (!faultPinAOut && !faultPinBOut)
    else $error("fault pin driven high");
  a_action_idle: assert property (faultPinAIn [*4] |-> faultActionA == 8'h00)
    else $error("fault action without a low pin");
endmodule // pm_regs_checker

bind power_manager_status_telemetry_regs pm_regs_checker pm_regs_checker_i (.clk_sys, .sys_rst,
  .cmdValid, .cmdWrite, .cmdCode, .pageSel, .chanIoutStatus, .inputStatus, .vinWord,
  .faultPinAIn, .faultPinAOut, .faultPinBOut, .faultActionA, .rdData, .cmdAck, .cmdRefused);

// *** host_bus_model.sv ***
// Host controller model issuing one byte or word command per call.
module host_bus_model (
  input  wire         clk_sys,
  input  wire  [15:0] rdData,
  input  wire         cmdAck,
  input  wire         cmdRefused,
  output logic        cmdValid,
  output logic        cmdWrite,
  output logic [7:0]  cmdCode,
  output logic [15:0] wrData
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle from time zero so the first command is a clean pulse.
  initial {cmdValid, cmdWrite, cmdCode, wrData} = 26'h0000000;
  // The one-cycle answer is read at the next falling edge; code and data are inverted.
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] r, output logic a, output logic f);
    @(negedge clk_sys);
    {cmdValid, cmdWrite, cmdCode, wrData} = {1'b1, w, c, d};
    @(negedge clk_sys);
    {cmdValid, cmdCode, wrData} = {1'b0, ~c, ~d};
    {r, a, f} = {rdData, cmdAck, cmdRefused};
  endtask
endmodule // host_bus_model

// *** test_power_manager_status_telemetry_regs.sv ***
// Self-checking bench for the power manager register bank.
`include "pm_regs_defs.vh"
module test_power_manager_status_telemetry_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, sys_rst, cmdValid, cmdWrite, telemValid, watchdogOkPin, extPull, ak, rf;
  logic        faultPinAOut, faultPinAOe, faultPinBOut, faultPinBOe, pwrGoodOut, cmdAck;
  logic        cmdRefused;
  logic [1:0]  pageSel, telemChan;
  logic [3:0]  chanFaultedOff, chanPowerGood;
  logic [7:0]  cmdCode, inputStatus, commStatus, faultActionA, faultActionB;
  logic [15:0] wrData, vinWord, dieTempWord, telemVout, telemIout, telemIoutFixed, telemPout;
  logic [15:0] telemTemp, rdData, rd, b1, b2, b3, scrS;
  logic [31:0] chanIoutStatus, chanTempStatus, chanVendorStatus, tv, seed;
  logic [15:0] scrP[4];
  logic [15:0] nvm[$];
  logic [23:0] dtab[13] = '{24'h980011, 24'hb30000, 24'hb40000, 24'hb98000, 24'hba8000,
    24'hd00080, 24'hd10f7b, 24'hd20000, 24'hd30000, 24'hd40000, 24'hd50000, 24'hd60000,
    24'hd90000};
  int          failures = 0, n_tests = 0, cyc = 0;
  // Open-drain fault wires: low when the design or the far side pulls.
  wire         faultPinAIn = !(faultPinAOe || extPull);
  wire         faultPinBIn = !(faultPinBOe || extPull);

  power_manager_status_telemetry_regs power_manager_status_telemetry_regs_i (.clk_sys,
    .sys_rst, .cmdValid, .cmdWrite, .cmdCode, .wrData, .pageSel, .chanIoutStatus,
    .inputStatus, .chanTempStatus, .commStatus, .chanVendorStatus, .vinWord, .dieTempWord,
    .telemValid, .telemChan, .telemVout, .telemIout, .telemIoutFixed, .telemPout, .telemTemp,
    .chanFaultedOff, .chanPowerGood, .watchdogOkPin, .faultPinAIn, .faultPinBIn,
    .faultPinAOut, .faultPinAOe, .faultPinBOut, .faultPinBOe, .faultActionA, .faultActionB,
    .pwrGoodOut, .rdData, .cmdAck, .cmdRefused);
  host_bus_model host_bus_model_i (.clk_sys, .rdData, .cmdAck, .cmdRefused, .cmdValid,
    .cmdWrite, .cmdCode, .wrData);

  // Xorshift source, so every run sees the same stimulus.
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Compare and count; a mismatch is reported at once.
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Access that is expected to be accepted or refused.
  task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d, input logic r);
    host_bus_model_i.xfer(w, c, d, rd, ak, rf);
    check({16'h0000, ak, rf}, {16'h0000, !r, r});
  endtask
  // Accepted read with the predicted word.
  task automatic rdc(input logic [7:0] c, input logic [15:0] e);
    host_bus_model_i.xfer(1'b0, c, 16'h0000, rd, ak, rf);
    check({ak, rf, rd}, {2'b10, e});
  endtask
  // One telemetry capture on channel 1; current, power and temperature are offsets of the voltage word.
  task automatic send(input logic [15:0] b, input logic [15:0] fx);
    @(negedge clk_sys);
    {telemValid, telemChan, telemVout, telemIout} = {3'b101, b, b + 16'h0001};
    {telemPout, telemTemp, telemIoutFixed} = {b + 16'h0002, b + 16'h0003, fx};
    @(negedge clk_sys);
    telemValid = 1'b0;
  endtask
  // The only place the run ends.
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // 10 MHz system clock.
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // The whole sequence needs well under a thousand cycles; a hang ends here.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      complete_run();
    end
  end

  initial begin
    {sys_rst, telemValid, extPull, watchdogOkPin, pageSel, telemChan} = 8'h80;
    {chanFaultedOff, chanPowerGood, inputStatus, commStatus, vinWord, dieTempWord} = 56'h0;
    {chanIoutStatus, chanTempStatus, chanVendorStatus} = 96'h0;
    {telemVout, telemIout, telemIoutFixed, telemPout, telemTemp} = 80'h0;
    seed = 32'h00000059;
    repeat (16) @(negedge clk_sys);
    sys_rst = 1'b0;
    // Defaults right after reset.
    for (int i = 0; i < 13; i++) begin
      rdc(dtab[i][23:16], dtab[i][15:0]);
    end
    $display("test defaults done");
    // Paged scratch per page, shared one written from the last page.
    for (int p = 0; p < 4; p++) begin
      pageSel = 2'(p);
      tv = rnd();
      scrP[p] = tv[15:0];
      acc(1'b1, `CMD_SCR_PAGED, scrP[p], 1'b0);
    end
    scrS = tv[31:16];
    acc(1'b1, `CMD_SCR_SHARED, scrS, 1'b0);
    {inputStatus, commStatus, vinWord} = rnd();
    chanIoutStatus = rnd();
    chanTempStatus = rnd();
    chanVendorStatus = rnd();
    dieTempWord = chanVendorStatus[31:16] ^ 16'h0f0f;
    for (int p = 0; p < 4; p++) begin
      pageSel = 2'(p);
      rdc(`CMD_SCR_PAGED, scrP[p]);
      rdc(`CMD_SCR_SHARED, scrS);
      rdc(`CMD_IOUT_FLAGS, {8'h00, chanIoutStatus[8*p +: 8]});
      rdc(`CMD_INPUT_FLAGS, {8'h00, inputStatus});
      rdc(`CMD_TEMP_FLAGS, {8'h00, chanTempStatus[8*p +: 8]});
      rdc(`CMD_COMM_FLAGS, {8'h00, commStatus});
      rdc(`CMD_VEND_FLAGS, {8'h00, chanVendorStatus[8*p +: 8]});
      rdc(`CMD_VIN, vinWord);
      rdc(`CMD_DIE_TEMP, dieTempWord);
    end
    acc(1'b1, `CMD_IOUT_FLAGS, 16'h0001, 1'b1);
    acc(1'b0, 8'h81, 16'h0000, 1'b1);
    $display("test status done");
    // Middle sample must move neither extreme; page 0 stays untouched.
    {b1, b2} = rnd();
    b3 = b1 ^ 16'h00ff;
    pageSel = 2'h1;
    send(b1, 16'h0100);
    send(b2, 16'h0300);
    send(b3, 16'h0200);
    rdc(`CMD_VOUT, b3);
    rdc(`CMD_IOUT, b3 + 16'h0001);
    rdc(`CMD_POUT, b3 + 16'h0002);
    rdc(`CMD_EXT_TEMP, b3 + 16'h0003);
    rdc(`CMD_IOUT_FIXED, 16'h0200);
    rdc(`CMD_IOUT_MAX, b2 + 16'h0001);
    rdc(`CMD_IOUT_MIN, b1 + 16'h0001);
    rdc(`CMD_SELF_HEAT, 16'h0000);
    pageSel = 2'h0;
    rdc(`CMD_IOUT_MAX, 16'h8000);
    rdc(`CMD_VOUT, 16'h0000);
    $display("test telemetry done");
    // Memory stays shut until unlocked; erase fills it and the port walks it with wrap.
    acc(1'b0, `CMD_NVM_DATA, 16'h0000, 1'b1);
    acc(1'b1, `CMD_NVM_ERASE, 16'h0001, 1'b1);
    acc(1'b1, `CMD_NVM_UNLOCK, {8'h00, `NVM_UNLOCK_KEY}, 1'b0);
    acc(1'b1, `CMD_NVM_ERASE, 16'h0001, 1'b0);
    acc(1'b1, `CMD_NVM_DATA, 16'h0000, 1'b1);
    repeat (66) @(negedge clk_sys);
    nvm = {};
    repeat (64) nvm.push_back(16'hffff);
    tv = rnd();
    for (int i = 0; i < 2; i++) begin
      nvm[i] = tv[16*i +: 16];
      acc(1'b1, `CMD_NVM_DATA, nvm[i], 1'b0);
    end
    for (int i = 2; i < 66; i++) begin
      rdc(`CMD_NVM_DATA, nvm[i % 64]);
    end
    acc(1'b1, `CMD_NVM_UNLOCK, 16'h0000, 1'b0);
    acc(1'b0, `CMD_NVM_DATA, 16'h0000, 1'b1);
    $display("test memory done");
    // Only a faulted channel with its propagation bit set pulls pin A.
    pageSel = 2'h2;
    acc(1'b1, `CMD_PROP_A, 16'h0001, 1'b0);
    chanFaultedOff = 4'h4;
    repeat (3) @(negedge clk_sys);
    check({16'h0000, faultPinAOe, faultPinBOe}, 18'h00002);
    chanFaultedOff = 4'hb;
    repeat (3) @(negedge clk_sys);
    check({16'h0000, faultPinAOe, faultPinBOe}, 18'h00000);
    tv = rnd();
    acc(1'b1, `CMD_RESP_A, {8'h00, tv[7:0]}, 1'b0);
    extPull = 1'b1;
    repeat (5) @(negedge clk_sys);
    check({2'b00, faultActionA, faultActionB}, {2'b00, tv[7:0], 8'h00});
    extPull = 1'b0;
    $display("test fault pins done");
    // Channels 0 and 2 plus the watchdog are mapped onto power good.
    acc(1'b1, `CMD_PG_MAP, 16'h0105, 1'b0);
    for (int i = 0; i < 6; i++) begin
      tv = (i == 0) ? 32'h00000015 : rnd();
      {watchdogOkPin, chanPowerGood} = tv[4:0];
      repeat (5) @(negedge clk_sys);
      check({17'h00000, pwrGoodOut}, {17'h00000, tv[0] & tv[2] & tv[4]});
    end
    $display("test power good done");
    complete_run();
  end
endmodule // test_power_manager_status_telemetry_regs
